// *** conv_timing.v ***
// sinc3 conversion timing and sequencing: start pin, start command, delay, settling
// assumes adc clock pin and start pins arrive asynchronously; registers over axi4-lite
//
// Operation
// RULE1: sinc3 magnitude response set by osr and clock
// RULE2: nulls at every multiple of data rate
// RULE3: 2.5, 5, 10 sps reject 50 and 60
// RULE4: 16.6 and 50 sps reject 50 only
// RULE5: 20 and 60 sps reject 60 only
// RULE6: bandwidth about 0.262 times data rate
// RULE7: all timing scales with adc clock
// RULE8: first two sinc3 results discarded after start
// RULE9: first result takes tabulated modulator periods
// RULE10: continuous results follow one data period apart
// RULE11: programmable delay before first conversion, default 14
// RULE12: modulator period equals sixteen adc clocks
// RULE13: three-bit delay field added to first time
// RULE14: continuous mode delays only before first conversion
// RULE15: compensation overhead before result available
// RULE16: start on pin rise or seventh sclk fall
// RULE17: suppressed results take no overhead, unreadable
// RULE18: same sequence both filters, sinc3 valid third
// RULE19: filter bit cleared selects sinc3
// RULE20: data ready only for settled results
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "conv_timing_defs.vh"

module conv_timing (
	input wire clock_i,
	input wire rst_n_i,
	input wire adc_clk_i,
	input wire start_pin_i,
	input wire sclk_i,
	input wire cs_n_i,
	input wire din_i,
	input wire [23:0] sample_i,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg data_ready_n_o,
	output reg busy_o
);

// ==========================================
// state codes
// ==========================================
localparam S_IDLE = 4'b0001;
localparam S_DELAY = 4'b0010;
localparam S_SAMPLE = 4'b0100;
localparam S_OVERHD = 4'b1000;

// ==========================================
// input synchronisers
// ==========================================
reg [1:0] aclk_sync_reg;
reg [1:0] start_sync_reg;
reg [1:0] sclk_sync_reg;
reg [1:0] cs_sync_reg;
reg [1:0] din_sync_reg;
reg aclk_last_reg;
reg start_last_reg;
reg sclk_last_reg;

// two flops per pin, then edge history from the second flop only
always @(posedge clock_i) begin
	if (!rst_n_i) begin
		aclk_sync_reg <= 2'b00;
		start_sync_reg <= 2'b00;
		sclk_sync_reg <= 2'b00;
		cs_sync_reg <= 2'b11;
		din_sync_reg <= 2'b00;
		aclk_last_reg <= 1'b0;
		start_last_reg <= 1'b0;
		sclk_last_reg <= 1'b0;
	end else begin
		aclk_sync_reg <= {aclk_sync_reg[0], adc_clk_i};
		start_sync_reg <= {start_sync_reg[0], start_pin_i};
		sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
		cs_sync_reg <= {cs_sync_reg[0], cs_n_i};
		din_sync_reg <= {din_sync_reg[0], din_i};
		aclk_last_reg <= aclk_sync_reg[1];
		start_last_reg <= start_sync_reg[1];
		sclk_last_reg <= sclk_sync_reg[1];
	end
end

wire aclk_rise = aclk_sync_reg[1] & ~aclk_last_reg;
wire start_rise = start_sync_reg[1] & ~start_last_reg;
wire sclk_fall = ~sclk_sync_reg[1] & sclk_last_reg & ~cs_sync_reg[1];

// ==========================================
// modulator period enable
// ==========================================
reg [7:0] div_reg;
reg mod_tick_reg;

// one pulse every sixteen adc clock rises
always @(posedge clock_i) begin
	if (!rst_n_i) begin
		div_reg <= 8'h00;
		mod_tick_reg <= 1'b0;
	end else begin
		mod_tick_reg <= 1'b0;
		if (aclk_rise) begin
			if (div_reg == `MOD_DIV - 8'd1) begin // RULE12 RULE7
				div_reg <= 8'h00;
				mod_tick_reg <= 1'b1;
			end else begin
				div_reg <= div_reg + 8'd1;
			end
		end
	end
end

// ==========================================
// serial start command
// ==========================================
reg [3:0] bit_cnt_reg;
reg [7:0] cmd_shift_reg;
reg cmd_start_reg;

// command 0x08 detected at the seventh falling edge (bits 7..1 seen)
always @(posedge clock_i) begin
	if (!rst_n_i) begin
		bit_cnt_reg <= 4'h0;
		cmd_shift_reg <= 8'h00;
		cmd_start_reg <= 1'b0;
	end else begin
		cmd_start_reg <= 1'b0;
		if (cs_sync_reg[1]) begin
			bit_cnt_reg <= 4'h0;
		end else if (sclk_fall) begin
			cmd_shift_reg <= {cmd_shift_reg[6:0], din_sync_reg[1]};
			bit_cnt_reg <= (bit_cnt_reg == 4'h7) ? 4'h0 : bit_cnt_reg + 4'h1;
			if (bit_cnt_reg + 4'h1 == `START_CMD_EDGE &&
				{cmd_shift_reg[5:0], din_sync_reg[1]} == 7'h04) begin
				cmd_start_reg <= 1'b1; // RULE16
			end
		end
	end
end

// ==========================================
// registers
// ==========================================
reg [31:0] ctrl_reg;
reg [31:0] rate_reg;
reg [31:0] gain_reg;
reg [23:0] data_reg;
reg new_data_reg;
reg [31:0] rd_data_next;
reg sw_start_reg;
reg sw_stop_reg;

wire sinc3_sel = ~rate_reg[`RATE_FILTER_BIT]; // RULE19
wire cont_mode = ctrl_reg[`CTRL_CONT_BIT];
wire [3:0] rate_code = rate_reg[3:0];
wire [2:0] delay_code = gain_reg[`GAIN_DELAY_LSB+2:`GAIN_DELAY_LSB];

// upper address bits or a misaligned address never reach a register
wire ar_bad = (s_axi_araddr[31:5] != 27'h000_0000) || (s_axi_araddr[1:0] != 2'b00) ||
	(s_axi_araddr[4:0] > `ADDR_DATA);
wire aw_bad = s_axi_awaddr[31:5] != 27'h000_0000;
wire [4:0] rd_index = ar_bad ? 5'h1f : s_axi_araddr[4:0];

// read mux
always @* begin
	case (rd_index)
	{1'b0, `ADDR_CTRL}: rd_data_next = ctrl_reg;
	{1'b0, `ADDR_RATE}: rd_data_next = rate_reg;
	{1'b0, `ADDR_GAIN}: rd_data_next = gain_reg;
	{1'b0, `ADDR_STAT}: rd_data_next = {30'h0000_0000, busy_o, new_data_reg};
	`ADDR_DATA: rd_data_next = {8'h00, data_reg};
	default: rd_data_next = 32'h0000_0000;
	endcase
end

wire aw_hit = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
wire ar_hit = s_axi_arvalid & ~s_axi_rvalid;
wire data_read = ar_hit && rd_index == `ADDR_DATA;
wire result_done;

// axi4-lite slave: write and address taken together, answer next cycle
always @(posedge clock_i) begin
	if (!rst_n_i) begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'b00;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= 2'b00;
		s_axi_rdata <= 32'h0000_0000;
		ctrl_reg <= `CTRL_RESET;
		rate_reg <= `RATE_RESET;
		gain_reg <= `GAIN_RESET;
		sw_start_reg <= 1'b0;
		sw_stop_reg <= 1'b0;
	end else begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_arready <= 1'b0;
		sw_start_reg <= 1'b0;
		sw_stop_reg <= 1'b0;
		if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		if (aw_hit && !s_axi_awready) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= 2'b00;
			case (aw_bad ? 5'h1f : s_axi_awaddr[4:0])
			{1'b0, `ADDR_CTRL}: begin
				if (s_axi_wstrb[0]) begin
					ctrl_reg[`CTRL_CONT_BIT] <= s_axi_wdata[`CTRL_CONT_BIT];
					sw_start_reg <= s_axi_wdata[`CTRL_START_BIT];
					sw_stop_reg <= s_axi_wdata[`CTRL_STOP_BIT];
				end
			end
			{1'b0, `ADDR_RATE}: if (s_axi_wstrb[0]) rate_reg[7:0] <= {3'b000, s_axi_wdata[4:0]};
			{1'b0, `ADDR_GAIN}: if (s_axi_wstrb[0]) gain_reg[7:0] <= s_axi_wdata[7:0]; // RULE13
			`ADDR_DATA: s_axi_bresp <= 2'b10;
			{1'b0, `ADDR_STAT}: s_axi_bresp <= 2'b10;
			default: s_axi_bresp <= 2'b10;
			endcase
		end
		if (ar_hit && !s_axi_arready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data_next;
			s_axi_rresp <= ar_bad ? 2'b10 : 2'b00;
		end
	end
end

// ==========================================
// period tables (modulator periods)
// ==========================================
reg [`MOD_CNT_W-1:0] data_period;
reg [`MOD_CNT_W-1:0] delay_periods;

// steady data period per rate; sinc3 first time is delay plus 3 periods plus overhead
always @* begin
	case (rate_code) // RULE2 RULE3 RULE4 RULE5 RULE6
	4'h0: data_period = `PERIOD_R0;
	4'h1: data_period = `PERIOD_R1;
	4'h2: data_period = `PERIOD_R2;
	4'h3: data_period = `PERIOD_R3;
	4'h4: data_period = `PERIOD_R4;
	4'h5: data_period = `PERIOD_R5;
	4'h6: data_period = `PERIOD_R6;
	4'h7: data_period = `PERIOD_R7;
	4'h8: data_period = `PERIOD_R8;
	4'h9: data_period = `PERIOD_R9;
	4'ha: data_period = `PERIOD_R10;
	4'hb: data_period = `PERIOD_R11;
	4'hc: data_period = `PERIOD_R12;
	default: data_period = `PERIOD_R13;
	endcase
end

// start delay choices, default code 0 gives 14 periods
always @* begin
	case (delay_code) // RULE11 RULE13
	3'd0: delay_periods = `DELAY_D0;
	3'd1: delay_periods = `DELAY_D1;
	3'd2: delay_periods = `DELAY_D2;
	3'd3: delay_periods = `DELAY_D3;
	3'd4: delay_periods = `DELAY_D4;
	3'd5: delay_periods = `DELAY_D5;
	3'd6: delay_periods = `DELAY_D6;
	default: delay_periods = `DELAY_D7;
	endcase
end

// compensation overhead is shorter at the fastest rates
wire [`MOD_CNT_W-1:0] overhead_periods = (rate_code >= `FAST_RATE_CODE) ?
	`OVERHEAD_FAST_PERIODS : `OVERHEAD_PERIODS; // RULE15 RULE9

// ==========================================
// conversion sequencer
// ==========================================
reg [3:0] state_reg;
reg [`MOD_CNT_W-1:0] cnt_reg;
reg [1:0] drop_reg;

wire start_req = start_rise | cmd_start_reg | sw_start_reg; // RULE16
wire last_tick = mod_tick_reg && cnt_reg == 20'd1;
// sinc3 still settling: this sample is suppressed
wire settling = sinc3_sel && drop_reg != 2'd0;
assign result_done = (state_reg == S_OVERHD) && last_tick;

// delay, then sample data periods; overhead only for results that are kept
always @(posedge clock_i) begin
	if (!rst_n_i) begin
		state_reg <= S_IDLE;
		cnt_reg <= 20'd0;
		drop_reg <= 2'd0;
		busy_o <= 1'b0;
	end else begin
		case (state_reg)
		S_IDLE: begin
			if (start_req) begin
				state_reg <= S_DELAY;
				cnt_reg <= delay_periods;
				drop_reg <= `SINC3_SETTLE_DROP; // RULE8 RULE18
				busy_o <= 1'b1;
			end
		end
		S_DELAY: begin
			if (sw_stop_reg) begin
				state_reg <= S_IDLE;
				busy_o <= 1'b0;
			end else if (last_tick) begin
				state_reg <= S_SAMPLE;
				cnt_reg <= data_period; // RULE9 RULE1
			end else if (mod_tick_reg)
				cnt_reg <= cnt_reg - 20'd1;
		end
		S_SAMPLE: begin
			if (sw_stop_reg) begin
				state_reg <= S_IDLE;
				busy_o <= 1'b0;
			end else if (last_tick) begin
				if (settling) begin
					drop_reg <= drop_reg - 2'd1; // RULE17 no overhead
					cnt_reg <= data_period;
				end else begin
					state_reg <= S_OVERHD; // RULE15
					cnt_reg <= overhead_periods;
				end
			end else if (mod_tick_reg)
				cnt_reg <= cnt_reg - 20'd1;
		end
		S_OVERHD: begin
			if (last_tick) begin
				if (cont_mode && !sw_stop_reg) begin
					// next result one data period later, no delay again
					state_reg <= S_SAMPLE; // RULE14 RULE10
					cnt_reg <= data_period - overhead_periods;
				end else begin
					state_reg <= S_IDLE;
					busy_o <= 1'b0;
				end
			end else if (mod_tick_reg)
				cnt_reg <= cnt_reg - 20'd1;
		end
		default: begin
			state_reg <= S_IDLE;
			busy_o <= 1'b0;
		end
		endcase
	end
end

// ==========================================
// result and data ready
// ==========================================
// only settled results latch and flag; set wins over a data read clear
always @(posedge clock_i) begin
	if (!rst_n_i) begin
		data_reg <= 24'h00_0000;
		new_data_reg <= 1'b0;
		data_ready_n_o <= 1'b1;
	end else begin
		if (result_done) begin
			data_reg <= sample_i;
			new_data_reg <= 1'b1; // RULE20
			data_ready_n_o <= 1'b0;
		end else if (data_read) begin
			new_data_reg <= 1'b0;
			data_ready_n_o <= 1'b1;
		end
	end
end

endmodule // conv_timing

// *** conv_timing_defs.vh ***
// constants for the sinc3 conversion timing block
// assumes inclusion by conv_timing.v only; times are counts of modulator periods
`ifndef CONV_TIMING_DEFS_VH
`define CONV_TIMING_DEFS_VH
// ==========================================
// clocking
// ==========================================
`define SYS_CLK_MHZ 50
`define MOD_DIV 8'd16
`define MOD_CNT_W 20
// ==========================================
// register map (byte addresses)
// ==========================================
`define ADDR_CTRL 4'h0
`define ADDR_RATE 4'h4
`define ADDR_GAIN 4'h8
`define ADDR_STAT 4'hc
`define ADDR_DATA 5'h10
`define CTRL_START_BIT 0
`define CTRL_CONT_BIT 1
`define CTRL_STOP_BIT 2
`define RATE_FILTER_BIT 4
`define GAIN_DELAY_LSB 5
`define CTRL_RESET 32'h0000_0002
`define RATE_RESET 32'h0000_0004
`define GAIN_RESET 32'h0000_0000
// ==========================================
// overheads and delays
// ==========================================
`define SINC3_SETTLE_DROP 2'd2
`define OVERHEAD_PERIODS 20'h0_0041
`define OVERHEAD_FAST_PERIODS 20'h0_0028
`define FAST_RATE_CODE 4'hb
`define START_CMD_EDGE 4'd7
// ==========================================
// data periods per rate code, start delays per delay code
// ==========================================
`define PERIOD_R0 20'h1_9000
`define PERIOD_R1 20'h0_c800
`define PERIOD_R2 20'h0_6400
`define PERIOD_R3 20'h0_3c00
`define PERIOD_R4 20'h0_3200
`define PERIOD_R5 20'h0_1400
`define PERIOD_R6 20'h0_10a8
`define PERIOD_R7 20'h0_0a00
`define PERIOD_R8 20'h0_0500
`define PERIOD_R9 20'h0_0280
`define PERIOD_R10 20'h0_0140
`define PERIOD_R11 20'h0_0100
`define PERIOD_R12 20'h0_0080
`define PERIOD_R13 20'h0_0040
`define DELAY_D0 20'h0_000e
`define DELAY_D1 20'h0_0019
`define DELAY_D2 20'h0_0040
`define DELAY_D3 20'h0_0100
`define DELAY_D4 20'h0_0400
`define DELAY_D5 20'h0_0800
`define DELAY_D6 20'h0_1000
`define DELAY_D7 20'h0_0001
`endif

// *** host_model.sv ***
// host controller model: start pin pulses and serial start commands
// assumes the block samples these lines with its own clock
`timescale 1ns/10ps
module host_model (
	output logic start_o,
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	// ==========
	// idle levels and host tasks
	// ==========
	initial begin
		start_o = 1'b0;
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	// rising edge on the start line
	task pulse_start;
		begin
			// step off the clock edge the caller woke on
			#5;
			start_o = 1'b1;
			#200;
			start_o = 1'b0;
		end
	endtask
	// byte msb first, changed on rising sclk so it stands at the falling edge
	task send_cmd(input logic [7:0] c);
		int i;
		begin
			#5;
			cs_n_o = 1'b0;
			for (i = 7; i >= 0; i--) begin
				#80 sclk_o = 1'b1;
				din_o = c[i];
				#80 sclk_o = 1'b0;
			end
			#80 cs_n_o = 1'b1;
			din_o = ~din_o; // released line shows no stale bit
		end
	endtask
endmodule // host_model

// *** conv_timing_asserts.sv ***
// checker of port timing for the conversion block
// assumes 20 ns clock, 80 ns adc clock and rate code 13 (4096-cycle data period) as the bench sets
`timescale 1ns/10ps
module conv_timing_chk (
	input wire clock_i,
	input wire rst_n_i,
	input wire s_axi_awvalid,
	input wire s_axi_wvalid,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] s_axi_rresp,
	input wire [31:0] s_axi_rdata,
	input wire data_ready_n_o,
	input wire busy_o
);
	// ==========
	// helpers and assertions
	// ==========
	logic [15:0] busy_cnt_reg;
	logic [15:0] gap_cnt_reg;
	logic in_run_reg;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// cycles busy, cycles since last result, inside a continuous run
	always @(posedge clock_i) begin
		busy_cnt_reg <= (rst_n_i && busy_o) ? busy_cnt_reg + 16'h0001 : 16'h0000;
		gap_cnt_reg <= (rst_n_i && !$fell(data_ready_n_o)) ? gap_cnt_reg + 16'h0001 : 16'h0000;
		in_run_reg <= rst_n_i && busy_o && (in_run_reg || $fell(data_ready_n_o));
	end
	AST_AW_TAKE:
	assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
		|=> s_axi_awready && s_axi_bvalid) else $error("write not answered");
	AST_AR_TAKE:
	assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
		|=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
	AST_R_DONE:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read repeated");
	AST_ERR_ZERO:
	assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
	AST_READY_IN_BUSY:
	assert property ($fell(data_ready_n_o) |-> $past(busy_o)) else $error("ready while idle");
	AST_READY_STAYS:
	assert property (!data_ready_n_o && !s_axi_arvalid && !s_axi_rvalid |=> !data_ready_n_o)
		else $error("ready lost without read");
	AST_FIRST_TIME:
	assert property ($fell(data_ready_n_o) && !in_run_reg |-> busy_cnt_reg
		inside {[15680:15744], [14848:14912], [7424:7552]}) else $error("first result time");
	AST_CONT_GAP:
	assert property ($fell(data_ready_n_o) && in_run_reg |-> gap_cnt_reg inside {[4088:4104]})
		else $error("continuous period");
	cover property ($fell(data_ready_n_o) && in_run_reg);
	cover property ($fell(data_ready_n_o) && !in_run_reg);
	cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // conv_timing_chk

// *** tb.sv ***
// testbench: register access, three start paths, result timing
// assumes host_model and the checker are compiled first
`timescale 1ns/10ps
module tb;
	// ==========
	// clocks, instances and tasks
	// ==========
	logic clock_i = 1'b0;
	logic adc_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [23:0] sample_i = 24'h5a_3c96;
	logic [31:0] s_axi_awaddr = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp;
	wire [1:0] s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire data_ready_n_o, busy_o, start_pin_i, sclk_i, cs_n_i, din_i;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	always #10 clock_i = ~clock_i;
	always #40 adc_clk_i = ~adc_clk_i;
	host_model host (.start_o(start_pin_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));
	conv_timing DUT (.clock_i, .rst_n_i, .adc_clk_i, .start_pin_i, .sclk_i, .cs_n_i, .din_i,
		.sample_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .data_ready_n_o, .busy_o);
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// write with address and data offered together
	task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clock_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	// cycles until ready falls, from one modulator period below to 8 cycles above the expected count
	task wait_rdy(input int e);
		int n;
		n = 0;
		while (data_ready_n_o !== 1'b0) begin
			@(posedge clock_i);
			n++;
		end
		chk(n >= e - 64 && n <= e + 8, 1'b1);
	endtask
	task get_result;
		axi_rd(32'h0000_0010, 32'h005a_3c96, 2'b00);
		repeat (2) @(posedge clock_i);
		chk(data_ready_n_o, 1'b1);
	endtask
	// hang guard
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		axi_rd(32'h0000_0000, 32'h0000_0002, 2'b00);
		axi_rd(32'h0000_0004, 32'h0000_0004, 2'b00);
		axi_rd(32'h0000_0008, 32'h0000_0000, 2'b00);
		axi_rd(32'h0000_0020, 32'h0000_0000, 2'b10);
		axi_wr(32'h0000_000c, 32'h0000_0001, 2'b10);
		axi_wr(32'h0000_0004, 32'h0000_000d, 2'b00);
		axi_wr(32'h0000_0000, 32'h0000_0001, 2'b00);
		wait_rdy(15744);
		get_result;
		chk(busy_o, 1'b0);
		host.send_cmd(8'h08);
		wait_rdy(15732);
		get_result;
		axi_wr(32'h0000_0004, 32'h0000_001d, 2'b00);
		axi_wr(32'h0000_0000, 32'h0000_0001, 2'b00);
		wait_rdy(7552);
		get_result;
		axi_wr(32'h0000_0004, 32'h0000_000d, 2'b00);
		axi_wr(32'h0000_0008, 32'h0000_00e0, 2'b00);
		axi_wr(32'h0000_0000, 32'h0000_0002, 2'b00);
		host.pulse_start;
		wait_rdy(14902);
		axi_rd(32'h0000_000c, 32'h0000_0003, 2'b00);
		get_result;
		wait_rdy(4088);
		get_result;
		axi_wr(32'h0000_0000, 32'h0000_0004, 2'b00);
		repeat (2) @(posedge clock_i);
		chk(busy_o, 1'b0);
		tally_and_finish;
	end
endmodule // tb

bind conv_timing conv_timing_chk chk_i (.clock_i, .rst_n_i, .s_axi_awvalid, .s_axi_wvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rresp, .s_axi_rdata, .data_ready_n_o, .busy_o);
